// *** dv/frc_ctrl_assertions.sv ***
// Port assertions for the fault retry controller.
// Assumes one clock domain and reset active high.
module frc_chk (
  // Clock and reset
  input logic       clk,
  input logic       rst,
  // Register port
  input logic       reg_wr,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata_q,
  // Fault, clearing and status
  input logic       fault_in,
  input logic       clear_bit,
  input logic       clear_faults,
  input logic       cmd_on,
  input logic       out_enable_q,
  input logic       fault_latched_q,
  input logic [2:0] attempts_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Shadow config
  // ----------
  logic [7:0] cfg_q;
  // Writes excluded: a new config may change the reaction
  wire        quiet = !clear_bit && !clear_faults && cmd_on && !reg_wr;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cfg_q <= 8'h00;
    else if (reg_wr && reg_addr == 8'hC4) cfg_q <= reg_wdata;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_rd_unmapped: assert property (reg_addr != 8'hC4 |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  chk_rd_config: assert property (reg_addr == 8'hC4 && !reg_wr
    |=> reg_rdata_q == cfg_q)
    else $error("config read mismatch");
  chk_latch_off: assert property (fault_latched_q |-> !out_enable_q)
    else $error("output on while latched");
  chk_latch_hold: assert property (fault_latched_q && quiet && $past(cmd_on)
    |=> fault_latched_q)
    else $error("latch dropped without clear");
  chk_clear_resets: assert property (clear_bit || clear_faults || !cmd_on
    |=> !fault_latched_q && attempts_q == 3'h0)
    else $error("clear did not reset sequence");
  chk_ignore_runs: assert property (cfg_q[7:6] == 2'h0 && out_enable_q && quiet
    |=> out_enable_q)
    else $error("ignore response dropped output");
  chk_retry_drop: assert property (cfg_q[7:6] == 2'h2 && out_enable_q && fault_in && quiet
    |=> !out_enable_q)
    else $error("disable response kept output on");
  chk_attempt_step: assert property ($changed(attempts_q)
    |-> attempts_q == $past(attempts_q) + 3'h1 || attempts_q == 3'h0)
    else $error("attempt count jumped");
  chk_attempt_cap: assert property (attempts_q <= 3'h6)
    else $error("attempt count above six");
  chk_no_retry: assert property (cfg_q[5:3] == 3'h0 |-> attempts_q == 3'h0)
    else $error("restart with retry code zero");
  cover property (fault_latched_q && attempts_q == 3'h6);
  cover property ($rose(out_enable_q) && attempts_q != 3'h0);
  cover property (cfg_q[7:6] == 2'h1 && fault_in && !out_enable_q);
endmodule // frc_chk

bind frc_ctrl frc_chk frc_chk_inst (.clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata_q,
  .fault_in, .clear_bit, .clear_faults, .cmd_on, .out_enable_q, .fault_latched_q, .attempts_q);

// *** dv/frc_host_model.sv ***
// Management host stand-in: byte writes, reads and clearing actions.
// Assumes callers enter tasks just after a rising edge.
module frc_host_model (
  // Clock
  input  logic       clk,
  // Register port
  output logic       reg_wr = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00,
  input  logic [7:0] reg_rdata_q,
  // Clearing
  output logic       clear_bit = 1'b0,
  output logic       clear_faults = 1'b0,
  output logic       cmd_on = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk) #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    @(posedge clk) #1;
    d = reg_rdata_q;
  endtask
  task automatic clr(input int kind);
    if (kind == 0) clear_bit = 1'b1;
    else if (kind == 1) clear_faults = 1'b1;
    else cmd_on = 1'b0;
    @(posedge clk) #1;
    clear_bit = 1'b0;
    clear_faults = 1'b0;
    cmd_on = 1'b1;
  endtask
endmodule // frc_host_model

// *** dv/tb_fault_retry_controller.sv ***
// Self-checking bench for the fault retry controller.
// Assumes the host model drives the register port and clears.
module tb_fault_retry_controller;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        fault_in = 1'b0;
  logic [15:0] unit_cycles = 16'h0001;
  logic        reg_wr, clear_bit, clear_faults, cmd_on, oe, fault_latched_q;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata_q, rv;
  logic [2:0]  attempts_q;
  int          failures = 0;
  int          samples_checked = 0;
  int          rises, low_len, on_len;
  always #25 clk = ~clk;
  frc_host_model frc_host_model_inst (.clk, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata_q,
    .clear_bit, .clear_faults, .cmd_on);
  frc_ctrl frc_ctrl_inst (.clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata_q, .fault_in,
    .clear_bit, .clear_faults, .cmd_on, .unit_cycles, .out_enable_q(oe), .fault_latched_q,
    .attempts_q);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Clear first so a stale count never meets the new config
  task automatic hit(input logic [7:0] cfg, input int n);
    logic prev;
    frc_host_model_inst.clr(0);
    frc_host_model_inst.wr(8'hC4, cfg);
    rises = 0;
    low_len = 0;
    on_len = 0;
    prev = oe;
    fault_in = 1'b1;
    repeat (n) begin
      @(posedge clk) #1;
      if (oe === 1'b1 && prev === 1'b0) rises++;
      if (oe === 1'b0 && rises == 0) low_len++;
      if (oe === 1'b1 && low_len == 0) on_len++;
      prev = oe;
    end
    fault_in = 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    @(posedge clk) #1;
    frc_host_model_inst.rd(8'hC4, rv);
    check("cfg reset", rv, 8'h00);
    frc_host_model_inst.wr(8'hC4, 8'hA5);
    frc_host_model_inst.rd(8'hC5, rv);
    check("unmapped", rv, 8'h00);
    frc_host_model_inst.rd(8'hC4, rv);
    check("cfg rw", rv, 8'hA5);
    for (int k = 0; k < 7; k++) begin
      hit({2'b10, k[2:0], 3'b000}, 80);
      check("on_len", on_len, 0);
      check("restarts", rises, k);
      check("attempts", attempts_q, k);
      repeat (8) @(posedge clk);
      #1 check("held off", {fault_latched_q, oe}, 2'b10);
      frc_host_model_inst.clr(k % 3);
      check("cleared", fault_latched_q, 1'b0);
    end
    hit(8'hB8, 120);
    check("endless", {fault_latched_q, rises > 6}, 2'b01);
    frc_host_model_inst.clr(2);
    check("seq reset", attempts_q, 3'h0);
    for (int n = 0; n < 8; n++) begin
      unit_cycles = 16'(n % 2 + 1);
      hit({5'b10001, n[2:0]}, 300);
      check("delay", low_len, ((n % 2 + 1) << n) + 1);
    end
    unit_cycles = 16'h0001;
    hit(8'h08, 30);
    check("ignore", on_len, 30);
    hit(8'h4A, 40);
    check("run on", on_len >= 4 && low_len > 0, 1'b1);
    hit(8'hC0, 20);
    check("latch now", {fault_latched_q, rises[1:0]}, 3'b100);
    report_and_stop();
  end
endmodule // tb_fault_retry_controller

// *** hw/frc_consts.vh ***
// Constants for the fault retry controller: register offset, field layout, codes.
// Assumes inclusion by the design files of the fault retry controller only.
`ifndef FRC_CONSTS_VH
`define FRC_CONSTS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define FRC_CFG_OFFSET    8'hC4
`define FRC_CFG_RESET     8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FRC_RESP_HI       7
`define FRC_RESP_LO       6
`define FRC_RETRY_HI      5
`define FRC_RETRY_LO      3
`define FRC_DELAY_HI      2
`define FRC_DELAY_LO      0

// ----------------------------------------
// Codes
// ----------------------------------------
`define FRC_RESP_IGNORE   2'h0
`define FRC_RESP_CONT     2'h1
`define FRC_RESP_RETRY    2'h2
`define FRC_RESP_LATCH    2'h3
`define FRC_RETRY_NONE    3'h0
`define FRC_RETRY_ALWAYS  3'h7

// ----------------------------------------
// Timing
// ----------------------------------------
`define FRC_UNIT_W        16
`define FRC_TMR_W         24
`define FRC_START_CYCLES  8'h04

`endif

// *** hw/frc_ctrl.v ***
// Fault retry controller: response register and restart sequencer.
// Assumes a decoded byte-write port from the management bus transport and
// a fault level already qualified by the detection logic.
//
// Operation
// - Retry codes 1..6 give exactly that many restart attempts after disable.
// - Once all attempts fail, output stays off until fault cleared.
// - Attempt starts are spaced by 2 to the delay field times the time unit.
// - Delay field n means 2 to the n time units, 1 to 128.
// - Delay field also times running-on for continue-then-act response.
// - Time unit length comes from a separate input, not this register.
// - Bits 7:6 pick ignore, continue then act, disable-retry, disable-latch.
// - Retry code 0 means no restart; off until fault cleared.
// - Bit clear, clear-all, off-then-on or power removal clears latched fault.
`include "frc_consts.vh"

module frc_ctrl #(
  parameter UNIT_W = `FRC_UNIT_W,
  parameter TMR_W  = `FRC_TMR_W
) (
  // Clock and reset (reset is bias power removal)
  input  wire              clk,
  input  wire              rst,
  // Register port
  input  wire              reg_wr,
  input  wire [7:0]        reg_addr,
  input  wire [7:0]        reg_wdata,
  output reg  [7:0]        reg_rdata_q,
  // Fault and clearing
  input  wire              fault_in,
  input  wire              clear_bit,
  input  wire              clear_faults,
  input  wire              cmd_on,
  input  wire [UNIT_W-1:0] unit_cycles,
  // Status and output control
  output reg               out_enable_q,
  output reg               fault_latched_q,
  output reg  [2:0]        attempts_q
);

  // ----------------------------------------
  // State codes
  // ----------------------------------------
  localparam [5:0] S_RUN     = 6'b000001;
  localparam [5:0] S_CONT    = 6'b000010;
  localparam [5:0] S_WAIT    = 6'b000100;
  localparam [5:0] S_START   = 6'b001000;
  localparam [5:0] S_LATCH   = 6'b010000;
  localparam [5:0] S_OFF     = 6'b100000;

  reg [5:0] state_q;
  reg [5:0] state_d;
  reg [7:0] cfg_q;
  reg [7:0] start_cnt_q;
  reg       cmd_on_q;
  reg       tmr_start;
  reg       tmr_abort;
  reg [2:0] att_d;
  wire      tmr_done;
  wire      clear_req;
  wire [1:0] resp;
  wire [2:0] retries;

  assign resp    = cfg_q[`FRC_RESP_HI:`FRC_RESP_LO];
  assign retries = cfg_q[`FRC_RETRY_HI:`FRC_RETRY_LO];

  // Off-then-on is seen as the return to on; an off level alone idles the block
  assign clear_req = clear_bit | clear_faults | (cmd_on & ~cmd_on_q);

  // True when another attempt is allowed after att attempts already made
  function more_left;
    input [2:0] code;
    input [2:0] att;
    begin
      if (code == `FRC_RETRY_ALWAYS)
        more_left = 1'b1;
      else
        more_left = (att < code);
    end
  endfunction

  // ----------------------------------------
  // Response register
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q       <= `FRC_CFG_RESET;
      reg_rdata_q <= 8'h00;
      cmd_on_q    <= 1'b0;
    end else begin
      cmd_on_q <= cmd_on;
      if (reg_wr && reg_addr == `FRC_CFG_OFFSET)
        cfg_q <= reg_wdata;
      reg_rdata_q <= (reg_addr == `FRC_CFG_OFFSET) ? cfg_q : 8'h00;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @* begin
    state_d   = state_q;
    att_d     = attempts_q;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    if (!cmd_on || clear_req) begin
      // Commanded off or cleared: fresh sequence next time
      state_d   = cmd_on ? S_RUN : S_OFF;
      att_d     = 3'h0;
      tmr_abort = 1'b1;
    end else begin
      case (state_q)
        S_OFF: state_d = S_RUN;
        S_RUN: begin
          if (fault_in) begin
            case (resp)
              `FRC_RESP_IGNORE: state_d = S_RUN;
              `FRC_RESP_CONT: begin
                state_d   = S_CONT;
                tmr_start = 1'b1;
              end
              `FRC_RESP_RETRY: begin
                if (more_left(retries, attempts_q)) begin
                  state_d   = S_WAIT;
                  tmr_start = 1'b1;
                end else begin
                  state_d = S_LATCH;
                end
              end
              default: state_d = S_LATCH;
            endcase
          end
        end
        S_CONT: begin
          // Still running; act only if the fault outlasts the delay
          if (!fault_in) begin
            state_d   = S_RUN;
            tmr_abort = 1'b1;
          end else if (tmr_done) begin
            if (more_left(retries, attempts_q)) begin
              state_d   = S_WAIT;
              tmr_start = 1'b1;
            end else begin
              state_d = S_LATCH;
            end
          end
        end
        S_WAIT: begin
          if (tmr_done) begin
            state_d = S_START;
            att_d   = attempts_q + 3'h1;
          end
        end
        S_START: begin
          // A fault inside the start window is a failed attempt
          if (fault_in) begin
            if (more_left(retries, attempts_q)) begin
              state_d   = S_WAIT;
              tmr_start = 1'b1;
            end else begin
              state_d = S_LATCH;
            end
          end else if (start_cnt_q == `FRC_START_CYCLES) begin
            state_d = S_RUN;
            att_d   = 3'h0;
          end
        end
        S_LATCH: state_d = S_LATCH;
        default: state_d = S_OFF;
      endcase
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q         <= S_OFF;
      attempts_q      <= 3'h0;
      start_cnt_q     <= 8'h00;
      out_enable_q    <= 1'b0;
      fault_latched_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      attempts_q <= (retries == `FRC_RETRY_ALWAYS && att_d == 3'h7) ? 3'h6 : att_d;
      start_cnt_q <= (state_d == S_START && state_q == S_START) ?
                     start_cnt_q + 8'h01 : 8'h00;
      out_enable_q    <= (state_d == S_RUN) | (state_d == S_CONT) | (state_d == S_START);
      fault_latched_q <= (state_d == S_LATCH);
    end
  end

  // ----------------------------------------
  // Delay timer
  // ----------------------------------------
  frc_delay_timer #(
    .UNIT_W (UNIT_W),
    .TMR_W  (TMR_W)
  ) u_timer (
    .clk         (clk),
    .rst         (rst),
    .start       (tmr_start),
    .abort       (tmr_abort),
    .delay_code  (cfg_q[`FRC_DELAY_HI:`FRC_DELAY_LO]),
    .unit_cycles (unit_cycles),
    // The sequencer only waits on the done pulse, so busy stays unread
    .busy_q      (),
    .done_q      (tmr_done)
  );

endmodule // frc_ctrl

// *** hw/frc_delay_timer.v ***
// Delay timer: counts 2**code time units, each unit a number of clock cycles.
// Assumes unit_cycles is stable while a count is running and is at least one.
`include "frc_consts.vh"

module frc_delay_timer #(
  parameter UNIT_W = `FRC_UNIT_W,
  parameter TMR_W  = `FRC_TMR_W
) (
  // Clock and reset
  input  wire              clk,
  input  wire              rst,
  // Control
  input  wire              start,
  input  wire              abort,
  input  wire [2:0]        delay_code,
  input  wire [UNIT_W-1:0] unit_cycles,
  // Status
  output reg               busy_q,
  output reg               done_q
);

  reg [TMR_W-1:0] cnt_q;
  wire [TMR_W-1:0] total;

  // Units grow as powers of two, so a shift suffices
  assign total = {{(TMR_W-UNIT_W){1'b0}}, unit_cycles} << delay_code;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= {TMR_W{1'b0}};
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (abort) begin
        busy_q <= 1'b0;
        cnt_q  <= {TMR_W{1'b0}};
      end else if (start) begin
        busy_q <= 1'b1;
        cnt_q  <= total - {{(TMR_W-1){1'b0}}, 1'b1};
      end else if (busy_q) begin
        if (cnt_q == {TMR_W{1'b0}}) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(TMR_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // frc_delay_timer
